// File: dv/modem_line_model.sv
// Behavioural modem that drives the four active-low control inputs.
// Assumes the bench calls set_levels just after a rising clock edge.
`timescale 1ns/1ps
module modem_line_model (
   // Control inputs of the port, active low
   output logic      cts_n,
   output logic      dsr_n,
   output logic      ri_n,
   output logic      cd_n,
   // Control outputs of the port, watched only
   input  wire logic dtr_n,
   input  wire logic rts_n
);
   // ------------------------------------------------------------
   // Line levels
   // ------------------------------------------------------------
   // Idle high, as a modem that has not yet answered leaves them
   initial {cd_n, ri_n, dsr_n, cts_n} = 4'hf;

   // Order of levels: carrier, ring, data-set-ready, clear-to-send
   task automatic set_levels(input logic [3:0] levels);
      {cd_n, ri_n, dsr_n, cts_n} <= levels;
   endtask
endmodule

// File: dv/uart_line_modem_status_tb.sv
// Self-checking bench for the line and modem status block.
// Assumes a single AHB-Lite master and a modem model on the pins.
`timescale 1ns/1ps
module uart_line_modem_status_tb;
   import uart_status_pkg::*;
   logic        clk, reset, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [3:0]  rx_err;
   logic        rx_exit, rx_full, tx_empty;
   logic        cts_n, dsr_n, ri_n, cd_n, dtr_n, rts_n;
   logic        dma_halt, status_irq, txrx_irq, modem_irq, soft_rst;
   int          miscompares, comparisons;
   logic [7:0]  loop_ctl [5] = '{8'h14, 8'h24, 8'h44, 8'h84, 8'hf4};
   logic [7:0]  loop_lvl [5] = '{8'h20, 8'h10, 8'h40, 8'h80, 8'hf0};

   // ------------------------------------------------------------
   // Clock, design and modem
   // ------------------------------------------------------------
   initial clk = 1'b0;
   always #50 clk = ~clk;

   uart_line_modem_status u_dut (
      .CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata),
      .HRESP(hresp), .RX_OVERRUN(rx_err[0]),
      .RX_PARITY_ERROR(rx_err[1]), .RX_FRAMING_ERROR(rx_err[2]),
      .RX_BREAK(rx_err[3]), .RX_EXIT(rx_exit), .RX_DATA_FULL(rx_full),
      .TX_DATA_EMPTY(tx_empty), .CTS_N(cts_n), .DSR_N(dsr_n),
      .RI_N(ri_n), .CD_N(cd_n), .DTR_N(dtr_n), .RTS_N(rts_n),
      .DMA_HALT(dma_halt), .UART_SOFT_RESET(soft_rst),
      .STATUS_IRQ(status_irq),
      .TXRX_IRQ(txrx_irq), .MODEM_IRQ(modem_irq));

   modem_line_model u_modem (
      .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n),
      .dtr_n(dtr_n), .rts_n(rts_n));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t ns: got %h expected %h",
                  $time, got, exp);
      end
   endtask

   // Single word transfer; only the watchdog ends a stalled wait
   task automatic bus(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, addr};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wdata;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdata = hrdata;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      logic [31:0] unused;
      bus(1'b1, addr, data, unused);
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      logic [31:0] got;
      bus(1'b0, addr, 32'h0, got);
      check(got, exp);
   endtask

   // Sampled mid-cycle so register updates of the edge have landed
   task automatic probe(input logic [5:0] exp);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({26'h0, dtr_n, rts_n, dma_halt, status_irq, txrx_irq,
             modem_irq}, {26'h0, exp});
      @(posedge clk);
   endtask

   task automatic pulse(input int idx);
      rx_err <= 4'h1 << idx;
      @(posedge clk);
      rx_err <= 4'h0;
   endtask

   // Pins pass a synchroniser, so allow it time before reading
   task automatic modem_step(input logic [3:0] lv, input logic [7:0] exp);
      u_modem.set_levels(lv);
      repeat (8) @(posedge clk);
      rd_chk(MODEM_STATUS_OFFSET, {24'h0, exp});
   endtask

   task automatic end_sim;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {reset, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
      {rx_err, rx_exit, rx_full, tx_empty} = 7'h0;
      miscompares = 0;
      comparisons = 0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd_chk(LINE_STATUS_OFFSET, 32'h0);
      rd_chk(MODEM_STATUS_OFFSET, 32'h0);
      rd_chk(8'h10, 32'h0);
      probe(6'h30);
      for (int i = 0; i < 4; i++) begin
         pulse(i);
         rd_chk(LINE_STATUS_OFFSET, 32'h1 << i);
         probe(6'h38);
         wr(LINE_STATUS_OFFSET, 32'h0);
         rd_chk(LINE_STATUS_OFFSET, 32'h1 << i);
         wr(LINE_STATUS_OFFSET, 32'h1 << i);
         rd_chk(LINE_STATUS_OFFSET, 32'h0);
         probe(6'h30);
      end
      wr(IRQ_MASK_OFFSET, 32'h2);
      pulse(3);
      probe(6'h3c);
      wr(LINE_STATUS_OFFSET, 32'hff);
      rd_chk(LINE_STATUS_OFFSET, 32'h0);
      probe(6'h30);
      rx_exit <= 1'b1;
      probe(6'h38);
      rd_chk(LINE_STATUS_OFFSET, 32'h0);
      rx_exit <= 1'b0;
      probe(6'h30);
      rx_full <= 1'b1;
      tx_empty <= 1'b1;
      wr(IRQ_MASK_OFFSET, 32'h0);
      rd_chk(LINE_STATUS_OFFSET, 32'h30);
      probe(6'h30);
      wr(IRQ_MASK_OFFSET, 32'h4);
      probe(6'h32);
      rx_full <= 1'b0;
      rd_chk(LINE_STATUS_OFFSET, 32'h20);
      probe(6'h32);
      tx_empty <= 1'b0;
      probe(6'h30);
      wr(IRQ_MASK_OFFSET, 32'h0);
      modem_step(4'b1110, 8'h11);
      modem_step(4'b1100, 8'h33);
      wr(MODEM_STATUS_OFFSET, 32'h0);
      rd_chk(MODEM_STATUS_OFFSET, 32'h33);
      wr(MODEM_STATUS_OFFSET, 32'hf);
      rd_chk(MODEM_STATUS_OFFSET, 32'h30);
      modem_step(4'b1000, 8'h70);
      modem_step(4'b1100, 8'h34);
      modem_step(4'b0100, 8'hbc);
      probe(6'h30);
      wr(IRQ_MASK_OFFSET, 32'h1);
      probe(6'h31);
      wr(MODEM_STATUS_OFFSET, 32'hf);
      probe(6'h30);
      wr(IRQ_MASK_OFFSET, 32'h0);
      modem_step(4'b0000, 8'hf0);
      for (int i = 0; i < 5; i++) begin
         wr(MODEM_CONTROL_OFFSET, {24'h0, loop_ctl[i]});
         repeat (8) @(posedge clk);
         bus(1'b0, MODEM_STATUS_OFFSET, 32'h0, rd);
         check(rd & 32'hf0, {24'h0, loop_lvl[i]});
      end
      probe(6'h30);
      wr(MODEM_CONTROL_OFFSET, 32'h30);
      repeat (8) @(posedge clk);
      bus(1'b0, MODEM_STATUS_OFFSET, 32'h0, rd);
      check(rd & 32'hf0, 32'hf0);
      probe(6'h00);
      u_modem.set_levels(4'hf);
      repeat (8) @(posedge clk);
      wr(MODEM_STATUS_OFFSET, 32'hf);
      rd_chk(MODEM_STATUS_OFFSET, 32'h0);
      // Soft reset: one-cycle pulse, flags cleared, bit reads back done
      pulse(0);
      wr(MODEM_CONTROL_OFFSET, 32'h1);
      @(negedge clk);
      check({31'h0, soft_rst}, 32'h1);
      @(posedge clk);
      @(negedge clk);
      check({31'h0, soft_rst}, 32'h0);
      @(posedge clk);
      rd_chk(MODEM_CONTROL_OFFSET, 32'h0);
      rd_chk(LINE_STATUS_OFFSET, 32'h0);
      probe(6'h30);
      end_sim();
   end

   // A stalled bus or lost edge would otherwise hang the run
   initial begin
      #2_000_000;
      miscompares++;
      end_sim();
   end
endmodule

// File: include/uart_status_pkg.sv
// Register map, field positions and reset values of the line and modem
// status block. Shared by the top module and its synchroniser.
package uart_status_pkg;

   // ------------------------------------------------------------
   // Register byte offsets on the bus
   // ------------------------------------------------------------
   localparam logic [7:0] LINE_STATUS_OFFSET   = 8'h00;
   localparam logic [7:0] MODEM_STATUS_OFFSET  = 8'h04;
   localparam logic [7:0] MODEM_CONTROL_OFFSET = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFFSET      = 8'h0c;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int OVERRUN_BIT        = 0;
   localparam int PARITY_BIT         = 1;
   localparam int FRAMING_BIT        = 2;
   localparam int BREAK_BIT          = 3;
   localparam int RECEIVE_FULL_BIT   = 4;
   localparam int TRANSMIT_EMPTY_BIT = 5;
   localparam int CTS_CHANGE_BIT     = 0;
   localparam int DSR_CHANGE_BIT     = 1;
   localparam int RING_TRAIL_BIT     = 2;
   localparam int CARRIER_CHANGE_BIT = 3;
   localparam int SOFT_RESET_BIT     = 0;
   localparam int LOOPBACK_BIT       = 2;
   localparam int DTR_BIT            = 4;
   localparam int RTS_BIT            = 5;
   localparam int LOOP_RING_BIT      = 6;
   localparam int LOOP_CARRIER_BIT   = 7;
   localparam int MODEM_IRQ_BIT      = 0;
   localparam int STATUS_IRQ_BIT     = 1;
   localparam int TXRX_IRQ_BIT       = 2;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [3:0] FLAGS_RESET         = 4'h0;
   localparam logic [3:0] LEVELS_RESET        = 4'h0;
   localparam logic [3:0] PIN_IDLE_RESET      = 4'hf;
   localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
   localparam logic [2:0] IRQ_MASK_RESET      = 3'h0;

   // Synchroniser depth, counted in flip-flops
   localparam int SYNC_STAGES = 3;

endpackage

// File: src/pin_sync.sv
// Three-flop synchroniser with agreement filter for the modem pins.
// Assumes asynchronous pins and one clock; idle level of a pin is high.
`timescale 1ns/1ps
module pin_sync
   import uart_status_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Pins and filtered levels
   input  wire logic [3:0] pins,
   output logic      [3:0] stable
);

   typedef struct packed {
      logic [3:0] first;
      logic [3:0] second;
      logic [3:0] third;
      logic [3:0] stable;
   } sync_type;

   sync_type s;
   sync_type next_s;

   always_comb begin
      next_s        = s;
      next_s.first  = pins;
      next_s.second = s.first;
      next_s.third  = s.second;
      // A change counts only once the last two stages agree
      for (int i = 0; i < 4; i++) begin
         if (s.second[i] == s.third[i]) begin
            next_s.stable[i] = s.third[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= {PIN_IDLE_RESET, PIN_IDLE_RESET, PIN_IDLE_RESET,
               PIN_IDLE_RESET};
      end else begin
         s <= next_s;
      end
   end

   assign stable = s.stable;

endmodule

// File: src/uart_line_modem_status.sv
// Line-status and modem-status logic of one serial port, with an
// AHB-Lite register slave. Assumes a single-master bus on CLK and
// receiver/transmitter strobes from logic on the same clock.
`timescale 1ns/1ps

module uart_line_modem_status
   import uart_status_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic             HREADYOUT,
   output logic [31:0]      HRDATA,
   output logic             HRESP,
   // Receiver and transmitter events and levels
   input  wire logic        RX_OVERRUN,
   input  wire logic        RX_PARITY_ERROR,
   input  wire logic        RX_FRAMING_ERROR,
   input  wire logic        RX_BREAK,
   input  wire logic        RX_EXIT,
   input  wire logic        RX_DATA_FULL,
   input  wire logic        TX_DATA_EMPTY,
   // Modem pins, active low
   input  wire logic        CTS_N,
   input  wire logic        DSR_N,
   input  wire logic        RI_N,
   input  wire logic        CD_N,
   output logic             DTR_N,
   output logic             RTS_N,
   // Port control and requests
   output logic             DMA_HALT,
   output logic             UART_SOFT_RESET,
   output logic             STATUS_IRQ,
   output logic             TXRX_IRQ,
   output logic             MODEM_IRQ
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  error_flags;
      logic [3:0]  change_flags;
      logic [3:0]  levels;
      logic [7:0]  modem_control;
      logic [2:0]  irq_mask;
      logic        write_pending;
      logic [7:0]  write_addr;
      logic [31:0] rdata;
      logic        hready;
      logic        halt;
      logic        soft_reset;
      logic        status_irq;
      logic        txrx_irq;
      logic        modem_irq;
      logic        dtr_n;
      logic        rts_n;
   } state_type;

   state_type s;
   state_type next_s;
   logic [3:0] pin_levels;

   function automatic logic hits(input logic [7:0] addr,
                                 input logic [7:0] offset);
      hits = (addr[7:2] == offset[7:2]);
   endfunction

   // ------------------------------------------------------------
   // Pin synchroniser (CTS, DSR, RI, CD order)
   // ------------------------------------------------------------
   pin_sync sync_inst (
      .clk    (CLK),
      .reset  (RESET),
      .pins   ({CD_N, RI_N, DSR_N, CTS_N}),
      .stable (pin_levels)
   );

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   logic        take;
   logic        do_write;
   logic [7:0]  wdata;
   logic [3:0]  error_set;
   logic [3:0]  error_clear;
   logic [3:0]  change_set;
   logic [3:0]  change_clear;
   logic [3:0]  new_levels;
   logic        loop;
   logic [7:0]  line_word;
   logic [7:0]  modem_word;

   always_comb begin
      next_s       = s;
      take         = HSEL && HREADY && HTRANS[1];
      do_write     = s.write_pending;
      wdata        = HWDATA[7:0];
      error_clear  = 4'h0;
      change_clear = 4'h0;
      loop         = s.modem_control[LOOPBACK_BIT];

      // Data phase of a write: write-one-to-clear flags, plain controls
      if (do_write && hits(s.write_addr, LINE_STATUS_OFFSET)) begin
         error_clear = wdata[3:0];
      end
      if (do_write && hits(s.write_addr, MODEM_STATUS_OFFSET)) begin
         change_clear = wdata[3:0];
      end
      if (do_write && hits(s.write_addr, MODEM_CONTROL_OFFSET)) begin
         next_s.modem_control = wdata;
      end else if (s.soft_reset) begin
         // Soft reset ends after one cycle; its bit reads back as done
         next_s.modem_control[SOFT_RESET_BIT] = 1'b0;
      end
      if (do_write && hits(s.write_addr, IRQ_MASK_OFFSET)) begin
         next_s.irq_mask = wdata[2:0];
      end

      // Effective modem levels: pins inverted, or control bits in loopback
      if (loop) begin
         new_levels = {s.modem_control[LOOP_CARRIER_BIT],
                       s.modem_control[LOOP_RING_BIT],
                       s.modem_control[DTR_BIT],
                       s.modem_control[RTS_BIT]};
      end else begin
         new_levels = ~pin_levels;
      end

      error_set = {RX_BREAK, RX_FRAMING_ERROR, RX_PARITY_ERROR,
                   RX_OVERRUN};
      change_set[CTS_CHANGE_BIT]     = new_levels[0] ^ s.levels[0];
      change_set[DSR_CHANGE_BIT]     = new_levels[1] ^ s.levels[1];
      // Ring level 1 means pin low, so a fall of the level is the edge
      change_set[RING_TRAIL_BIT]     = s.levels[2] & ~new_levels[2];
      change_set[CARRIER_CHANGE_BIT] = new_levels[3] ^ s.levels[3];
      next_s.levels = new_levels;

      // Hardware set wins over a clear in the same cycle
      next_s.error_flags  = (s.error_flags & ~error_clear) | error_set;
      next_s.change_flags = (s.change_flags & ~change_clear) | change_set;
      if (s.soft_reset) begin
         next_s.error_flags  = FLAGS_RESET;
         next_s.change_flags = FLAGS_RESET;
      end

      next_s.soft_reset = next_s.modem_control[SOFT_RESET_BIT] &&
                          !s.soft_reset;
      next_s.halt = (|next_s.error_flags) || RX_EXIT;
      next_s.status_irq = next_s.irq_mask[STATUS_IRQ_BIT] &&
                          (|next_s.error_flags);
      next_s.txrx_irq = next_s.irq_mask[TXRX_IRQ_BIT] &&
                        (RX_DATA_FULL || TX_DATA_EMPTY);
      next_s.modem_irq = next_s.irq_mask[MODEM_IRQ_BIT] &&
                         (|next_s.change_flags);
      // Loopback parks the modem outputs inactive
      next_s.dtr_n = !(next_s.modem_control[DTR_BIT] &&
                       !next_s.modem_control[LOOPBACK_BIT]);
      next_s.rts_n = !(next_s.modem_control[RTS_BIT] &&
                       !next_s.modem_control[LOOPBACK_BIT]);

      // Read words built from post-write state so a read right after a
      // write sees the written value
      line_word  = {2'b00, TX_DATA_EMPTY, RX_DATA_FULL,
                    next_s.error_flags};
      modem_word = {next_s.levels, next_s.change_flags};

      // Address phase: zero wait states, read data registered here
      next_s.hready        = 1'b1;
      next_s.write_pending = take && HWRITE;
      next_s.write_addr    = HADDR[7:0];
      if (take && !HWRITE) begin
         if (hits(HADDR[7:0], LINE_STATUS_OFFSET)) begin
            next_s.rdata = {24'h000000, line_word};
         end else if (hits(HADDR[7:0], MODEM_STATUS_OFFSET)) begin
            next_s.rdata = {24'h000000, modem_word};
         end else if (hits(HADDR[7:0], MODEM_CONTROL_OFFSET)) begin
            next_s.rdata = {24'h000000, next_s.modem_control};
         end else if (hits(HADDR[7:0], IRQ_MASK_OFFSET)) begin
            next_s.rdata = {29'h00000000, next_s.irq_mask};
         end else begin
            next_s.rdata = 32'h00000000;
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         s.error_flags   <= FLAGS_RESET;
         s.change_flags  <= FLAGS_RESET;
         s.levels        <= LEVELS_RESET;
         s.modem_control <= MODEM_CONTROL_RESET;
         s.irq_mask      <= IRQ_MASK_RESET;
         s.write_pending <= 1'b0;
         s.write_addr    <= 8'h00;
         s.rdata         <= 32'h00000000;
         s.hready        <= 1'b1;
         s.halt          <= 1'b0;
         s.soft_reset    <= 1'b0;
         s.status_irq    <= 1'b0;
         s.txrx_irq      <= 1'b0;
         s.modem_irq     <= 1'b0;
         s.dtr_n         <= 1'b1;
         s.rts_n         <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign HREADYOUT       = s.hready;
   assign HRDATA          = s.rdata;
   assign HRESP           = 1'b0;
   assign DMA_HALT        = s.halt;
   assign UART_SOFT_RESET = s.soft_reset;
   assign STATUS_IRQ      = s.status_irq;
   assign TXRX_IRQ        = s.txrx_irq;
   assign MODEM_IRQ       = s.modem_irq;
   assign DTR_N           = s.dtr_n;
   assign RTS_N           = s.rts_n;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   // Soft reset takes two steps: the pulse, then cleared flags
   sequence soft_reset_written;
      do_write && hits(s.write_addr, MODEM_CONTROL_OFFSET) &&
      wdata[SOFT_RESET_BIT] && !s.soft_reset;
   endsequence

   sequence flags_cleared;
      UART_SOFT_RESET ##1 (s.error_flags == FLAGS_RESET &&
                           s.change_flags == FLAGS_RESET &&
                           !UART_SOFT_RESET);
   endsequence

   sequence loop_held;
      s.modem_control[LOOPBACK_BIT] && !s.soft_reset;
   endsequence

   overrun_set_a: assert property (RX_OVERRUN && !s.soft_reset
      |=> s.error_flags[OVERRUN_BIT])
      else $error("overrun flag not set");
   parity_set_a: assert property (RX_PARITY_ERROR && !s.soft_reset
      |=> s.error_flags[PARITY_BIT])
      else $error("parity flag not set");
   framing_set_a: assert property (RX_FRAMING_ERROR && !s.soft_reset
      |=> s.error_flags[FRAMING_BIT])
      else $error("framing flag not set");
   break_set_a: assert property (RX_BREAK && !s.soft_reset
      |=> s.error_flags[BREAK_BIT])
      else $error("break flag not set");
   overrun_hold_a: assert property (s.error_flags[OVERRUN_BIT]
      && !(do_write && hits(s.write_addr, LINE_STATUS_OFFSET) &&
           wdata[OVERRUN_BIT]) && !s.soft_reset
      |=> s.error_flags[OVERRUN_BIT])
      else $error("overrun flag lost without clear");
   dma_halt_a: assert property ((|s.error_flags) |-> DMA_HALT)
      else $error("error flag set but DMA not halted");
   status_gate_a: assert property (STATUS_IRQ |->
      s.irq_mask[STATUS_IRQ_BIT] && (|s.error_flags))
      else $error("status interrupt while masked or idle");
   txrx_irq_a: assert property (s.irq_mask[TXRX_IRQ_BIT] &&
      !(do_write && hits(s.write_addr, IRQ_MASK_OFFSET)) &&
      (RX_DATA_FULL || TX_DATA_EMPTY) |=> TXRX_IRQ)
      else $error("transmit or receive interrupt missing");
   ring_edge_a: assert property ($past(s.levels[2]) &&
      !s.levels[2] && !$past(s.soft_reset) |-> s.change_flags[RING_TRAIL_BIT])
      else $error("ring trailing edge not flagged");
   cts_change_a: assert property (s.levels[0] != $past(s.levels[0])
      && !$past(s.soft_reset) |-> s.change_flags[CTS_CHANGE_BIT])
      else $error("clear-to-send change not flagged");
   change_clear_a: assert property ($fell(s.change_flags[0]) |->
      $past(change_clear[0] || s.soft_reset))
      else $error("change flag cleared without a write of one");
   loop_mirror_a: assert property (loop_held |=>
      s.levels == {$past(s.modem_control[7]), $past(s.modem_control[6]),
                   $past(s.modem_control[4]), $past(s.modem_control[5])})
      else $error("loopback levels do not follow modem control");
   pin_levels_a: assert property (!s.modem_control[LOOPBACK_BIT]
      |=> s.levels == ~$past(pin_levels))
      else $error("modem levels do not follow pins");
   reserved_zero_a: assert property (HRDATA[31:8] == 24'h000000)
      else $error("upper read data not zero");
   dsr_change_a: assert property (s.levels[1] != $past(s.levels[1])
      && !$past(s.soft_reset) |-> s.change_flags[DSR_CHANGE_BIT])
      else $error("data-set-ready change not flagged");
   carrier_change_a: assert property (s.levels[3] != $past(s.levels[3])
      && !$past(s.soft_reset) |-> s.change_flags[CARRIER_CHANGE_BIT])
      else $error("carrier-detect change not flagged");
   ring_only_a: assert property ($rose(s.change_flags[RING_TRAIL_BIT])
      |-> $past(s.levels[2]) && !s.levels[2])
      else $error("ring flag set without a trailing edge");
   parity_cause_a: assert property ($rose(s.error_flags[PARITY_BIT])
      |-> $past(RX_PARITY_ERROR))
      else $error("parity flag set without a parity error");
   line_reserved_a: assert property (take && !HWRITE &&
      hits(HADDR[7:0], LINE_STATUS_OFFSET) |=> HRDATA[7:6] == 2'b00)
      else $error("reserved line-status bits read nonzero");
   txrx_masked_a: assert property (TXRX_IRQ |->
      s.irq_mask[TXRX_IRQ_BIT])
      else $error("transmit or receive interrupt while masked");
   loop_park_a: assert property (s.modem_control[LOOPBACK_BIT] |->
      DTR_N && RTS_N)
      else $error("modem outputs active in loopback");
   exit_halt_a: assert property (RX_EXIT |=> DMA_HALT)
      else $error("exit condition did not halt DMA");
   soft_reset_a: assert property (soft_reset_written |=> flags_cleared)
      else $error("soft reset did not clear the status flags");
   soft_done_a: assert property (UART_SOFT_RESET &&
      !(do_write && hits(s.write_addr, MODEM_CONTROL_OFFSET))
      |=> !s.modem_control[SOFT_RESET_BIT])
      else $error("soft reset bit did not read back as done");

endmodule
